// *** src/dacc_pkg.sv ***
// Purpose: Shared constants and types for the dual-channel converter control block
// Assumes: 100 MHz MCLK
// Notes:   Control register fields sit in the low data bits; D11:D10 carry the address
package dacc_pkg;
	localparam int DATA_W        = 12;
	localparam int FIFO_DEPTH    = 16;
	localparam int CNT_W         = $clog2(FIFO_DEPTH + 1);
	localparam int RA_LSB        = 10;
	localparam int RA_MSB        = 11;
	localparam logic [1:0] ADDR_CR0 = 2'h0;
	localparam logic [1:0] ADDR_CR1 = 2'h1;

	localparam int CR0_W         = 6;
	localparam int CR0_CONT      = 0;
	localparam int CR0_EN_A      = 1;
	localparam int CR0_EN_B      = 2;
	localparam int CR0_DIFF      = 3;
	localparam int CR0_SCAN      = 4;
	localparam int CR0_STROBE    = 5;
	localparam int CR0_FIFO_CLR  = 6;
	localparam logic [CR0_W-1:0] CR0_RESET = 6'h06;

	localparam int CR1_W         = 6;
	localparam int CR1_POL       = 0;
	localparam int CR1_PULSE     = 1;
	localparam int CR1_LVL_LSB   = 2;
	localparam int CR1_LVL_W     = 4;
	localparam logic [CR1_W-1:0] CR1_RESET = 6'h01;

	localparam int CLK_PERIOD_NS = 10;
	localparam int OSC_PERIOD_NS = 20;
	localparam int OSC_DIV       = (OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OSC_W         = 4;
	localparam int CONV_TICKS    = 4;
	localparam int CONV_W        = 3;

	typedef enum logic [3:0] {
		S_IDLE   = 4'b0001,
		S_CONV   = 4'b0010,
		S_PUSH_A = 4'b0100,
		S_PUSH_B = 4'b1000
	} dacc_state_t;
endpackage : dacc_pkg

// *** src/dacc_fifo.sv ***
// Purpose: Result buffer, first in first out, valid/ready on both sides
// Assumes: Synchronous clear, clock enable freezes contents
// Notes:   Head word is presented combinationally while not empty
`timescale 1ns/1ps
module dacc_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 16
) (
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire logic                       ce,
	input  wire logic                       clr,
	input  wire logic                       in_valid,
	output logic                            in_ready,
	input  wire logic [WIDTH-1:0]           in_data,
	output logic                            out_valid,
	input  wire logic                       out_ready,
	output logic [WIDTH-1:0]                out_data,
	output logic [$clog2(DEPTH+1)-1:0]      count
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [PW-1:0]    wr_ptr_ff;
	logic [PW-1:0]    rd_ptr_ff;
	logic [CW-1:0]    cnt_ff;
	logic             do_push;
	logic             do_pop;

	assign in_ready  = (cnt_ff != CW'(DEPTH));
	assign out_valid = (cnt_ff != '0);
	assign out_data  = mem_ff[rd_ptr_ff];
	assign count     = cnt_ff;
	assign do_push   = ce && !clr && in_valid && in_ready;
	assign do_pop    = ce && !clr && out_ready && out_valid;

	always_ff @(posedge clk) begin
		if (do_push) begin
			mem_ff[wr_ptr_ff] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			cnt_ff    <= '0;
		end else if (ce && clr) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			cnt_ff    <= '0;
		end else begin
			if (do_push) begin
				wr_ptr_ff <= PW'(wr_ptr_ff + 1'b1);
			end
			if (do_pop) begin
				rd_ptr_ff <= PW'(rd_ptr_ff + 1'b1);
			end
			if (do_push && !do_pop) begin
				cnt_ff <= CW'(cnt_ff + 1'b1);
			end else if (do_pop && !do_push) begin
				cnt_ff <= CW'(cnt_ff - 1'b1);
			end
		end
	end

	property p_full;
		@(posedge clk) disable iff (!rst_n)
		(ce && !clr && !out_ready && cnt_ff == CW'(DEPTH)) |=> (cnt_ff == CW'(DEPTH)) && !in_ready;
	endproperty
	a_full: assert property (p_full)
		else $error("buffer accepts data beyond its depth");

	property p_order;
		@(posedge clk) disable iff (!rst_n || !ce || clr)
		(do_push && cnt_ff == '0 && !out_ready) |=> (out_valid && out_data == $past(in_data));
	endproperty
	a_order: assert property (p_order)
		else $error("oldest result not at the head");
endmodule : dacc_fifo

// *** src/dacc_osc.sv ***
// Purpose: Internal conversion oscillator, one tick per period while enabled
// Assumes: Enable low holds the counter cleared
// Notes:   Stopping it outside single conversions saves toggling power
`timescale 1ns/1ps
module dacc_osc (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	input  wire logic en,
	output logic      tick
);
	import dacc_pkg::*;

	logic [OSC_W-1:0] cnt_ff;

	assign tick = en && (cnt_ff == OSC_W'(OSC_DIV - 1));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= '0;
		end else if (ce) begin
			if (!en || tick) begin
				cnt_ff <= '0;
			end else begin
				cnt_ff <= OSC_W'(cnt_ff + 1'b1);
			end
		end
	end
endmodule : dacc_osc

// *** src/dacc_top.sv ***
// Purpose: Conversion sequencing and parallel host port of a dual-channel converter
// Assumes: All inputs synchronous to MCLK; core results valid whenever sampled
// Notes:   Edges of strobes are found by comparing with the previous sample
// How it works
// - Results are 12 bits wide and the sequencer keeps up with 8 MSPS.
// - Both core results are captured in the same cycle, channels enable singly or as one pair.
// - Scan mode pushes every enabled channel in turn from one sample.
// - Results go into a sixteen word buffer.
// - A control bit picks single or continuous conversion.
// - Single conversions are timed by the internal oscillator.
// - In continuous mode each rising edge of the conversion input samples and the oscillator stops.
// - In single mode a falling edge samples all selected inputs and starts one conversion.
// - The first select is honoured only when low.
// - The second select is honoured only when high, together with the first.
// - The ready output follows the buffer fill level with a programmable polarity.
// - The ready output can be a steady level or a one cycle pulse.
// - Data bits 11 and 10 pick control register 0 or 1 on a write.
// - Overflow rises when a result is lost and falls only on reset or buffer clear.
// - The write input is a read/write direction line or a write strobe with a separate read strobe.
`timescale 1ns/1ps
module dacc_top (
	input  wire logic                     MCLK,
	input  wire logic                     NRST,
	input  wire logic                     CE,
	input  wire logic                     CONVERSION_CLOCK_INPUT,
	input  wire logic                     SELECT_LOW_ACTIVE_N,
	input  wire logic                     SELECT_HIGH_ACTIVE,
	input  wire logic                     WRITE_STROBE_N,
	input  wire logic                     READ_STROBE_N,
	input  wire logic [dacc_pkg::DATA_W-1:0] DATA_IN,
	output logic      [dacc_pkg::DATA_W-1:0] DATA_OUT,
	output logic                          DATA_OE,
	input  wire logic [dacc_pkg::DATA_W-1:0] CORE_RESULT_A,
	input  wire logic [dacc_pkg::DATA_W-1:0] CORE_RESULT_B,
	output logic                          HOLD_STROBE,
	output logic                          OSC_RUNNING,
	output logic                          RESULT_READY_SIGNAL,
	output logic                          BUFFER_OVERFLOW_FLAG
);
	import dacc_pkg::*;

	function automatic logic is_addr(
		input logic [DATA_W-1:0] d,
		input logic [1:0]        a
	);
		is_addr = (d[RA_MSB:RA_LSB] == a);
	endfunction : is_addr

	logic [1:0]        rst_sync_ff;
	logic              rst_n;
	logic              conv_prev_ff;
	logic              sel_prev_ff;
	logic              wr_prev_ff;
	logic              rd_prev_ff;
	logic [CR0_W-1:0]  cr0_ff;
	logic [CR1_W-1:0]  cr1_ff;
	dacc_state_t       state_ff;
	dacc_state_t       nxt_state;
	dacc_state_t       first_st;
	logic [CONV_W-1:0] conv_cnt_ff;
	logic [DATA_W-1:0] hold_a_ff;
	logic [DATA_W-1:0] hold_b_ff;
	logic [DATA_W-1:0] dout_ff;
	logic              hold_ff;
	logic              ovf_ff;
	logic              ready_ff;
	logic              cond_prev_ff;
	logic              selected;
	logic              acc_start;
	logic              strobe_mode;
	logic              wr_ev;
	logic              rd_ev;
	logic              fifo_clr;
	logic              mode_cont;
	logic              scan;
	logic              use_a;
	logic              use_b;
	logic              any_en;
	logic              conv_fall;
	logic              conv_rise;
	logic              sample_go;
	logic              osc_en;
	logic              osc_tick;
	logic              push_valid;
	logic              push_ready;
	logic [DATA_W-1:0] push_data;
	logic              pop_valid;
	logic [DATA_W-1:0] pop_data;
	logic [CNT_W-1:0]  fill;
	logic [CNT_W-1:0]  thresh;
	logic              cond;
	logic              pol;
	logic              pulse_mode;
	logic              ready_act;
	logic [CR1_W-1:0]  din_low;

	// Reset is asserted at once and released two clocks later
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_ff[1];

	// Host port decode
	assign selected    = !SELECT_LOW_ACTIVE_N && SELECT_HIGH_ACTIVE;
	assign acc_start   = selected && !sel_prev_ff;
	assign strobe_mode = cr0_ff[CR0_STROBE];
	// Direction line picks the access at the start of the select window; the drive enable follows it throughout
	assign wr_ev = strobe_mode ? (selected && !WRITE_STROBE_N && wr_prev_ff)
	                           : (acc_start && !WRITE_STROBE_N);
	assign rd_ev = strobe_mode ? (selected && !READ_STROBE_N && rd_prev_ff)
	                           : (acc_start && WRITE_STROBE_N);
	assign DATA_OE = selected && (strobe_mode ? !READ_STROBE_N : WRITE_STROBE_N);
	assign fifo_clr = wr_ev && is_addr(DATA_IN, ADDR_CR0) && DATA_IN[CR0_FIFO_CLR];
	assign din_low  = DATA_IN[CR1_W-1:0];

	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			conv_prev_ff <= 1'b1;
			sel_prev_ff  <= 1'b0;
			wr_prev_ff   <= 1'b1;
			rd_prev_ff   <= 1'b1;
		end else if (CE) begin
			conv_prev_ff <= CONVERSION_CLOCK_INPUT;
			sel_prev_ff  <= selected;
			wr_prev_ff   <= WRITE_STROBE_N;
			rd_prev_ff   <= READ_STROBE_N;
		end
	end

	// Control registers; the clear bit is an action, not stored
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			cr0_ff <= CR0_RESET;
		end else if (CE && wr_ev && is_addr(DATA_IN, ADDR_CR0)) begin
			cr0_ff <= DATA_IN[CR0_W-1:0];
		end
	end

	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			cr1_ff <= CR1_RESET;
		end else if (CE && wr_ev && is_addr(DATA_IN, ADDR_CR1)) begin
			cr1_ff <= din_low;
		end
	end

	// Conversion sequencing
	assign mode_cont = cr0_ff[CR0_CONT];
	assign scan      = cr0_ff[CR0_SCAN];
	// Differential pair yields one result, carried on the A path
	assign use_a     = cr0_ff[CR0_EN_A] || cr0_ff[CR0_DIFF];
	assign use_b     = cr0_ff[CR0_EN_B] && !cr0_ff[CR0_DIFF];
	assign any_en    = use_a || use_b;
	assign first_st  = use_a ? S_PUSH_A : S_PUSH_B;
	assign conv_fall = conv_prev_ff && !CONVERSION_CLOCK_INPUT;
	assign conv_rise = !conv_prev_ff && CONVERSION_CLOCK_INPUT;
	assign sample_go = (state_ff == S_IDLE) && any_en
	                   && (mode_cont ? conv_rise : conv_fall);
	assign osc_en    = !mode_cont && (state_ff == S_CONV);

	dacc_osc u_osc (
		.clk   (MCLK),
		.rst_n (rst_n),
		.ce    (CE),
		.en    (osc_en),
		.tick  (osc_tick)
	);

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			S_IDLE: begin
				if (sample_go) begin
					nxt_state = mode_cont ? first_st : S_CONV;
				end
			end
			S_CONV: begin
				if (mode_cont || (osc_tick && conv_cnt_ff == CONV_W'(CONV_TICKS - 1))) begin
					nxt_state = mode_cont ? S_IDLE : first_st;
				end
			end
			S_PUSH_A: begin
				nxt_state = (scan && use_b) ? S_PUSH_B : S_IDLE;
			end
			S_PUSH_B: begin
				nxt_state = S_IDLE;
			end
			default: begin
				nxt_state = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= S_IDLE;
		end else if (CE) begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			conv_cnt_ff <= '0;
		end else if (CE) begin
			if (state_ff != S_CONV) begin
				conv_cnt_ff <= '0;
			end else if (osc_tick) begin
				conv_cnt_ff <= CONV_W'(conv_cnt_ff + 1'b1);
			end
		end
	end

	// Both channels captured together so they share one sampling instant
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			hold_a_ff <= '0;
			hold_b_ff <= '0;
			hold_ff   <= 1'b0;
		end else if (CE) begin
			hold_ff <= sample_go;
			if (sample_go) begin
				hold_a_ff <= CORE_RESULT_A;
				hold_b_ff <= CORE_RESULT_B;
			end
		end
	end

	assign push_valid = (state_ff == S_PUSH_A) || (state_ff == S_PUSH_B);
	assign push_data  = (state_ff == S_PUSH_A) ? hold_a_ff : hold_b_ff;

	dacc_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (MCLK),
		.rst_n     (rst_n),
		.ce        (CE),
		.clr       (fifo_clr),
		.in_valid  (push_valid),
		.in_ready  (push_ready),
		.in_data   (push_data),
		.out_valid (pop_valid),
		.out_ready (rd_ev),
		.out_data  (pop_data),
		.count     (fill)
	);

	// A push the buffer refuses is a lost result; set beats clear
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			ovf_ff <= 1'b0;
		end else if (CE) begin
			if (push_valid && !push_ready) begin
				ovf_ff <= 1'b1;
			end else if (fifo_clr) begin
				ovf_ff <= 1'b0;
			end
		end
	end

	// Read data is latched at the read event and held stable until a later read pops a word
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			dout_ff <= '0;
		end else if (CE && rd_ev && pop_valid) begin
			dout_ff <= pop_data;
		end
	end

	// Ready output
	assign thresh     = CNT_W'(cr1_ff[CR1_LVL_LSB +: CR1_LVL_W]) + CNT_W'(1);
	assign cond       = (fill >= thresh);
	assign pol        = cr1_ff[CR1_POL];
	assign pulse_mode = cr1_ff[CR1_PULSE];
	assign ready_act  = (RESULT_READY_SIGNAL == pol);

	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			cond_prev_ff <= 1'b0;
			ready_ff     <= 1'b0;
		end else if (CE) begin
			cond_prev_ff <= cond;
			if (pulse_mode) begin
				ready_ff <= (cond && !cond_prev_ff) ? pol : !pol;
			end else begin
				ready_ff <= cond ? pol : !pol;
			end
		end
	end

	assign DATA_OUT             = dout_ff;
	assign HOLD_STROBE          = hold_ff;
	assign OSC_RUNNING          = osc_en;
	assign RESULT_READY_SIGNAL  = ready_ff;
	assign BUFFER_OVERFLOW_FLAG = ovf_ff;

	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!rst_n || !CE);

	property p_osc_off;
		mode_cont |-> !OSC_RUNNING ##1 (state_ff != S_CONV);
	endproperty
	a_osc_off: assert property (p_osc_off)
		else $error("oscillator runs in continuous mode");

	property p_single;
		(state_ff == S_IDLE && !mode_cont && conv_fall && any_en)
		|=> (state_ff == S_CONV)[*8] ##1 (state_ff != S_CONV);
	endproperty
	a_single: assert property (p_single)
		else $error("single conversion not timed by oscillator");

	property p_sim;
		sample_go |=> (hold_a_ff == $past(CORE_RESULT_A)) && (hold_b_ff == $past(CORE_RESULT_B))
		              && HOLD_STROBE;
	endproperty
	a_sim: assert property (p_sim)
		else $error("channels not sampled together");

	property p_cont;
		(state_ff == S_IDLE && mode_cont && conv_rise && any_en) |=> push_valid;
	endproperty
	a_cont: assert property (p_cont)
		else $error("continuous edge did not push a result");

	property p_scan;
		(state_ff == S_PUSH_A && scan && use_b) |=> (state_ff == S_PUSH_B) ##1 (state_ff == S_IDLE);
	endproperty
	a_scan: assert property (p_scan)
		else $error("scan did not convert second input");

	property p_ovf_set;
		(push_valid && !push_ready) |=> BUFFER_OVERFLOW_FLAG;
	endproperty
	a_ovf_set: assert property (p_ovf_set)
		else $error("overflow not flagged");

	property p_ovf_keep;
		(BUFFER_OVERFLOW_FLAG && !fifo_clr) |=> BUFFER_OVERFLOW_FLAG;
	endproperty
	a_ovf_keep: assert property (p_ovf_keep)
		else $error("overflow cleared without buffer reset");

	property p_nosel;
		!selected |=> $stable(cr0_ff) && $stable(cr1_ff);
	endproperty
	a_nosel: assert property (p_nosel)
		else $error("registers changed while not selected");

	property p_addr;
		(wr_ev && DATA_IN[RA_MSB:RA_LSB] == ADDR_CR1)
		|=> (cr1_ff == $past(din_low)) && $stable(cr0_ff);
	endproperty
	a_addr: assert property (p_addr)
		else $error("address bits misrouted the write");

	property p_pulse;
		(pulse_mode && ready_act) |=> !ready_act || $changed(cr1_ff);
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("pulse output held longer than one cycle");

	property p_level;
		(!pulse_mode && $stable(cr1_ff) && cond) |=> (RESULT_READY_SIGNAL == $past(pol));
	endproperty
	a_level: assert property (p_level)
		else $error("ready level does not follow fill");

	property p_oe;
		(selected && (strobe_mode ? !READ_STROBE_N : !WRITE_STROBE_N))
		|-> (DATA_OE == strobe_mode);
	endproperty
	a_oe: assert property (p_oe)
		else $error("data drive wrong for strobe mode");
endmodule : dacc_top

// *** sim/dacc_host_model.sv ***
// Purpose: Host processor model for the converter's parallel port
// Assumes: Bus lines change just after a rising clock edge
// Notes:   Released data lines show the inverse of the last word written
`timescale 1ns/1ps
module dacc_host_model (
	input  wire logic        clk,
	output logic             sel_n,
	output logic             sel_h,
	output logic             wr_n,
	output logic             rd_n,
	output logic             conv,
	output logic [11:0]      dout,
	input  wire logic [11:0] din,
	input  wire logic        oe
);
	logic strobe_mode = 1'b0;

	initial begin
		sel_n = 1'b1;
		sel_h = 1'b0;
		wr_n  = 1'b1;
		rd_n  = 1'b1;
		conv  = 1'b1;
		dout  = 12'h000;
	end

	task automatic conv_set(input logic v);
		@(posedge clk);
		conv <= v;
	endtask : conv_set

	task automatic wr(input logic [1:0] a, input logic clr, input logic [5:0] v);
		@(posedge clk);
		sel_n <= 1'b0;
		sel_h <= 1'b1;
		wr_n  <= strobe_mode;
		dout  <= {a, 3'h0, clr, v};
		if (strobe_mode) begin
			@(posedge clk);
			wr_n <= 1'b0;
		end
		@(posedge clk);
		sel_n <= 1'b1;
		sel_h <= 1'b0;
		wr_n  <= 1'b1;
		dout  <= ~dout;
		@(posedge clk);
	endtask : wr

	// Select levels are arguments so refused accesses can be made on purpose
	task automatic rd(input logic sl, input logic sh, output logic e, output logic [11:0] d);
		@(posedge clk);
		sel_n <= sl;
		sel_h <= sh;
		if (strobe_mode) begin
			@(posedge clk);
			rd_n <= 1'b0;
		end
		#1;
		e = oe;
		@(posedge clk);
		sel_n <= 1'b1;
		sel_h <= 1'b0;
		rd_n  <= 1'b1;
		#1;
		d = din;
		@(posedge clk);
	endtask : rd
endmodule : dacc_host_model

// *** sim/dacc_top_tb.sv ***
// Purpose: Self-checking bench for the converter control block
// Assumes: Clock enable dropped once to check that state freezes
// Notes:   Core results are set by the bench before each conversion start
`timescale 1ns/1ps
module dacc_top_tb;
	import dacc_pkg::*;
	logic              MCLK   = 1'b0;
	logic              NRST   = 1'b0;
	logic              ce     = 1'b1;
	logic [DATA_W-1:0] core_a = 12'h000;
	logic [DATA_W-1:0] core_b = 12'h000;
	wire               sel_n, sel_h, wr_n, rd_n, conv, oe, hold, osc, rdy, ovf;
	wire  [DATA_W-1:0] din, dout;
	int                err_count = 0;
	int                cmp_count = 0;
	logic              e;
	logic [DATA_W-1:0] d;

	always #5 MCLK = ~MCLK;

	dacc_top u_dacc_top (.MCLK(MCLK), .NRST(NRST), .CE(ce), .CONVERSION_CLOCK_INPUT(conv),
		.SELECT_LOW_ACTIVE_N(sel_n), .SELECT_HIGH_ACTIVE(sel_h), .WRITE_STROBE_N(wr_n),
		.READ_STROBE_N(rd_n), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(oe),
		.CORE_RESULT_A(core_a), .CORE_RESULT_B(core_b), .HOLD_STROBE(hold),
		.OSC_RUNNING(osc), .RESULT_READY_SIGNAL(rdy), .BUFFER_OVERFLOW_FLAG(ovf));

	dacc_host_model u_dacc_host_model (.clk(MCLK), .sel_n(sel_n), .sel_h(sel_h), .wr_n(wr_n),
		.rd_n(rd_n), .conv(conv), .dout(din), .din(dout), .oe(oe));

	task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp, input string m);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, m, seen, exp);
		end
	endtask : chk

	task automatic summarize();
		$display("Counts: %0d comparisons, %0d mismatches", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : summarize

	task automatic hang(input string m);
		err_count++;
		$display("mismatch at %0t: %s timed out", $time, m);
		summarize();
	endtask : hang

	task automatic w(input logic [1:0] a, input logic clr, input logic [5:0] v);
		u_dacc_host_model.wr(a, clr, v);
		#1;
	endtask : w

	task automatic r(input logic sl, input logic sh);
		u_dacc_host_model.rd(sl, sh, e, d);
	endtask : r

	// One start edge on the conversion input, then time for the push to settle
	task automatic conv_one();
		u_dacc_host_model.conv_set(1'b0);
		u_dacc_host_model.conv_set(1'b1);
		repeat (3) @(posedge MCLK);
		#1;
	endtask : conv_one

	task automatic t_single();
		int n;
		core_a <= 12'h123;
		core_b <= 12'h456;
		w(ADDR_CR0, 1'b0, 6'h16);
		u_dacc_host_model.conv_set(1'b0);
		n = 0;
		while (hold !== 1'b1) begin
			n++;
			if (n > 5) hang("hold strobe");
			@(posedge MCLK);
			#1;
		end
		chk(osc, 1'b1, "oscillator on");
		n = 0;
		while (osc === 1'b1 && n < 20) begin
			n++;
			@(posedge MCLK);
			#1;
		end
		chk(12'(n), 12'h008, "oscillator cycles");
		u_dacc_host_model.conv_set(1'b1);
		repeat (3) @(posedge MCLK);
		#1;
		chk(rdy, 1'b1, "ready after single");
		r(1'b1, 1'b1);
		chk(e, 1'b0, "low select off");
		chk(d, 12'h000, "no pop low select");
		r(1'b0, 1'b0);
		chk(e, 1'b0, "high select off");
		chk(d, 12'h000, "no pop high select");
		r(1'b0, 1'b1);
		chk(e, 1'b1, "drive on read");
		chk(d, 12'h123, "first word");
		r(1'b0, 1'b1);
		chk(d, 12'h456, "second word");
		$display("single conversion test done");
	endtask : t_single

	task automatic t_cont();
		w(ADDR_CR0, 1'b0, 6'h03);
		for (int i = 0; i < 17; i++) begin
			core_a <= 12'h100 + 12'(i);
			u_dacc_host_model.conv_set(1'b0);
			u_dacc_host_model.conv_set(1'b1);
			@(posedge MCLK);
			#1;
			chk(osc, 1'b0, "oscillator stopped");
			@(posedge MCLK);
		end
		repeat (3) @(posedge MCLK);
		#1;
		chk(ovf, 1'b1, "overflow set");
		for (int i = 0; i < 16; i++) begin
			r(1'b0, 1'b1);
			chk(d, 12'h100 + 12'(i), "buffer order");
		end
		r(1'b0, 1'b1);
		chk(d, 12'h10f, "empty read keeps data");
		chk(ovf, 1'b1, "overflow sticky");
		w(ADDR_CR0, 1'b1, 6'h03);
		chk(ovf, 1'b0, "overflow cleared");
		$display("continuous conversion test done");
	endtask : t_cont

	task automatic t_ready();
		int n;
		w(2'h2, 1'b0, 6'h00);
		chk(rdy, 1'b0, "unmapped write ignored");
		w(ADDR_CR1, 1'b0, 6'h00);
		chk(rdy, 1'b1, "active low idle");
		core_a <= 12'h3c3;
		conv_one();
		chk(rdy, 1'b0, "active low asserted");
		r(1'b0, 1'b1);
		chk(d, 12'h3c3, "ready word");
		@(posedge MCLK);
		#1;
		chk(rdy, 1'b1, "active low released");
		w(ADDR_CR1, 1'b0, 6'h03);
		u_dacc_host_model.conv_set(1'b0);
		u_dacc_host_model.conv_set(1'b1);
		n = 0;
		repeat (8) begin
			@(posedge MCLK);
			#1;
			if (rdy === 1'b1) n++;
		end
		chk(12'(n), 12'h001, "pulse width");
		r(1'b0, 1'b1);
		$display("ready output test done");
	endtask : t_ready

	task automatic t_strobe();
		w(ADDR_CR0, 1'b0, 6'h23);
		u_dacc_host_model.strobe_mode = 1'b1;
		core_a <= 12'h5a5;
		conv_one();
		r(1'b0, 1'b1);
		chk(e, 1'b1, "strobe read drive");
		chk(d, 12'h5a5, "strobe read data");
		w(ADDR_CR1, 1'b0, 6'h00);
		chk(rdy, 1'b1, "strobe write taken");
		$display("strobe mode test done");
	endtask : t_strobe

	// Mid-run reset, a write while frozen, then differential and second-input-only modes
	task automatic t_modes();
		@(posedge MCLK);
		NRST <= 1'b0;
		repeat (2) @(posedge MCLK);
		NRST <= 1'b1;
		repeat (3) @(posedge MCLK);
		#1;
		chk(rdy, 1'b0, "mid-run reset ready");
		chk(dout, 12'h000, "mid-run reset data");
		u_dacc_host_model.strobe_mode = 1'b0;
		@(posedge MCLK);
		ce <= 1'b0;
		w(ADDR_CR1, 1'b0, 6'h00);
		@(posedge MCLK);
		ce <= 1'b1;
		repeat (2) @(posedge MCLK);
		#1;
		chk(rdy, 1'b0, "frozen write ignored");
		w(ADDR_CR1, 1'b0, 6'h05);
		w(ADDR_CR0, 1'b0, 6'h1f);
		core_a <= 12'h7e1;
		core_b <= 12'h2b4;
		conv_one();
		chk(rdy, 1'b0, "below threshold");
		core_b <= 12'h1c8;
		w(ADDR_CR0, 1'b0, 6'h15);
		conv_one();
		chk(rdy, 1'b1, "threshold reached");
		r(1'b0, 1'b1);
		chk(d, 12'h7e1, "differential word");
		r(1'b0, 1'b1);
		chk(d, 12'h1c8, "second input alone");
		$display("mode and freeze test done");
	endtask : t_modes

	initial begin
		repeat (2) @(posedge MCLK);
		#1;
		chk(dout, 12'h000, "reset data");
		chk(rdy, 1'b0, "reset ready");
		chk(ovf, 1'b0, "reset overflow");
		chk(osc, 1'b0, "reset oscillator");
		repeat (3) @(posedge MCLK);
		NRST <= 1'b1;
		repeat (3) @(posedge MCLK);
		t_single();
		t_cont();
		t_ready();
		t_strobe();
		t_modes();
		summarize();
	end
endmodule : dacc_top_tb
